// [bench/conditional_instruction_evaluator_test.sv]
// self-checking bench for the conditional instruction evaluator
`timescale 1ns/100ps
`default_nettype none

module conditional_instruction_evaluator_test;
    logic        clock_i             = 1'b0;
    logic        rst_b_i             = 1'b0;
    logic        instr_valid_i       = 1'b0;
    logic [15:0] instr_i             = 16'h0000;
    logic [15:0] main_sum_register_i = 16'h0000;
    logic        overflow_i          = 1'b0;
    logic        carry_i             = 1'b0;
    logic        test_control_flag_i = 1'b0;
    logic        branch_input_pin_i  = 1'b1;
    logic        cond_valid_o;
    logic        cond_met_o;
    logic        flag_met_o;
    logic        arith_met_o;
    logic [3:0]  arith_condition_field_o;
    logic [3:0]  exp_field           = 4'h0;
    logic        exp_arith           = 1'b0;
    logic        exp_flag            = 1'b0;
    int          n_fail              = 0;
    int          check_count         = 0;

    conditional_instruction_evaluator i_conditional_instruction_evaluator
    (
        .clock_i                 (clock_i),
        .rst_b_i                 (rst_b_i),
        .instr_valid_i           (instr_valid_i),
        .instr_i                 (instr_i),
        .main_sum_register_i     (main_sum_register_i),
        .overflow_i              (overflow_i),
        .carry_i                 (carry_i),
        .test_control_flag_i     (test_control_flag_i),
        .branch_input_pin_i      (branch_input_pin_i),
        .cond_valid_o            (cond_valid_o),
        .cond_met_o              (cond_met_o),
        .flag_met_o              (flag_met_o),
        .arith_met_o             (arith_met_o),
        .arith_condition_field_o (arith_condition_field_o)
    );

    // ========================================================================
    // 50 MHz core clock
    always #10 clock_i = ~clock_i;

    task automatic check(input logic ok, input string msg);
        check_count++;
        if (ok !== 1'b1)
        begin
            n_fail++;
            $display("MISMATCH at %0t: %s", $time, msg);
        end
    endtask

    // outputs must match the last expectation; valid pulse given separately
    task automatic check_outs(input logic vld);
        check(cond_valid_o === vld, "valid pulse");
        check(arith_condition_field_o === exp_field, "condition field");
        check(arith_met_o === exp_arith, "arithmetic match");
        check(flag_met_o === exp_flag, "flag match");
        check(cond_met_o === (exp_arith | exp_flag), "overall met");
    endtask

    // one request; expectation built from the instruction fields, answer one edge later
    task automatic req(input logic [15:0] ins, input logic [15:0] sum,
                       input logic ovf, input logic cry, input logic tc);
        instr_valid_i = 1'b1;
        instr_i = ins;
        main_sum_register_i = sum;
        overflow_i = ovf;
        carry_i = cry;
        test_control_flag_i = tc;
        exp_field = {sum == 16'h0000, sum[15], ovf, cry};
        exp_arith = |(ins[3:0] & ~(exp_field ^ ins[7:4]));
        case (ins[9:8])
            2'b00:   exp_flag = ~branch_input_pin_i;
            2'b01:   exp_flag = tc;
            2'b10:   exp_flag = ~tc;
            default: exp_flag = 1'b0;
        endcase
        @(posedge clock_i);
        #1;
        check_outs(1'b1);
    endtask

    // no request: pulse drops, results hold
    task automatic idle_check();
        instr_valid_i = 1'b0;
        @(posedge clock_i);
        #1;
        check_outs(1'b0);
    endtask

    // pin passes a two-flop synchroniser, so let it settle first
    task automatic t_flag_select();
        for (int p = 0; p < 2; p++)
        begin
            branch_input_pin_i = p[0];
            idle_check();
            idle_check();
            idle_check();
            for (int s = 0; s < 4; s++)
                for (int t = 0; t < 2; t++)
                    req({6'h00, s[1:0], 8'h00}, 16'h0001, 1'b0, 1'b0, t[0]);
        end
        idle_check();
    endtask

    // each condition set alone, tested with its state bit set and with it clear
    task automatic t_cond_order();
        for (int i = 0; i < 4; i++)
            for (int s = 0; s < 2; s++)
                req({8'h03, 4'(s * (1 << i)), 4'(1 << i)},
                    (i == 3) ? 16'h0000 : ((i == 2) ? 16'h8000 : 16'h0001),
                    i == 1, i == 0, 1'b0);
        idle_check();
    endtask

    // every mask against all-clear, all-set and 0110 states, back to back
    task automatic t_mask_state();
        for (int m = 0; m < 16; m++)
        begin
            req({8'h03, 4'h0, m[3:0]}, 16'h8000, 1'b1, 1'b0, 1'b1);
            req({8'h03, 4'hF, m[3:0]}, 16'h8000, 1'b1, 1'b0, 1'b1);
            req({8'h03, 4'h6, m[3:0]}, 16'h0000, 1'b0, 1'b1, 1'b1);
        end
        idle_check();
    endtask

    // zero-set, negative-clear pattern over sign boundaries
    task automatic t_nonneg();
        req(16'h038C, 16'h0000, 1'b0, 1'b0, 1'b0);
        req(16'h038C, 16'h7FFF, 1'b1, 1'b1, 1'b0);
        req(16'h038C, 16'h8000, 1'b0, 1'b0, 1'b0);
        req(16'h038C, 16'hFFFF, 1'b1, 1'b1, 1'b0);
        idle_check();
    endtask

    // reset in mid-run clears held results; first cycle after release is usable
    task automatic t_mid_reset();
        req(16'h03F1, 16'h0000, 1'b1, 1'b1, 1'b1);
        rst_b_i       = 1'b0;
        instr_valid_i = 1'b0;
        exp_field     = 4'h0;
        exp_arith     = 1'b0;
        exp_flag      = 1'b0;
        @(posedge clock_i);
        #1;
        check_outs(1'b0);
        @(posedge clock_i);
        #1;
        rst_b_i = 1'b1;
        req(16'h0088, 16'h0000, 1'b0, 1'b0, 1'b0);
        idle_check();
    endtask

    task automatic give_verdict();
        if (n_fail == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // ========================================================================
    // main sequence
    initial
    begin
        repeat (12) @(posedge clock_i);
        #1;
        check_outs(1'b0);
        rst_b_i = 1'b1;
        t_flag_select();
        t_cond_order();
        t_mask_state();
        t_nonneg();
        t_mid_reset();
        give_verdict();
    end
endmodule

`default_nettype wire

// [src/arith_cond_if.sv]
// carrier between the evaluator top and its arithmetic match stage
`timescale 1ns/100ps
`default_nettype none

interface arith_cond_if;
    logic [cond_eval_pkg::COND_W-1:0] mask;
    logic [cond_eval_pkg::COND_W-1:0] state;
    logic [cond_eval_pkg::COND_W-1:0] cond;
    logic                             met;

    // ========================================================================
    // requester drives the fields, evaluator answers
    modport evaluator
    (
        input  mask,
        input  state,
        input  cond,
        output met
    );
    modport requester
    (
        output mask,
        output state,
        output cond,
        input  met
    );
endinterface

`default_nettype wire

// [src/arith_cond_match.sv]
// combinational match of the arithmetic conditions against mask and state
`timescale 1ns/100ps
`default_nettype none

module arith_cond_match
(
    arith_cond_if.evaluator ac
);
    logic [cond_eval_pkg::COND_W-1:0] agree;
    logic [cond_eval_pkg::COND_W-1:0] picked;

    // ========================================================================
    // state polarity compare
    assign agree  = ~(ac.cond ^ ac.state);
    assign picked = agree & ac.mask;
    assign ac.met = |picked;

endmodule

`default_nettype wire

// [src/cond_eval_pkg.sv]
// constants and types shared by the conditional instruction evaluator
package cond_eval_pkg;

    // ========================================================================
    // widths
    localparam int INSTR_W = 16;
    localparam int DATA_W  = 16;
    localparam int COND_W  = 4;
    localparam int SEL_W   = 2;

    // ========================================================================
    // instruction field positions
    localparam int MASK_LSB  = 0;
    localparam int STATE_LSB = 4;
    localparam int SEL_LSB   = 8;

    // ========================================================================
    // arithmetic condition bit order: zero, negative, overflow, carry
    localparam int COND_ZERO = 3;
    localparam int COND_NEG  = 2;
    localparam int COND_OVF  = 1;
    localparam int COND_CRY  = 0;

    // ========================================================================
    // reset values
    localparam logic              RST_BIT  = 1'b0;
    localparam logic [COND_W-1:0] RST_COND = 4'h0;

    // ========================================================================
    // flag select pair codes, in encoding order 00, 01, 10, 11
    typedef enum logic [SEL_W-1:0]
    {
        SEL_PIN_LOW,
        SEL_TC_SET,
        SEL_TC_CLEAR,
        SEL_NONE
    } flag_sel_t;

endpackage

// [src/conditional_instruction_evaluator.sv]
// condition evaluation for conditional instructions of the core decoder
// Functional notes
// - select pair 00 pin low, 01 flag set, 10 flag clear, 11 none
// - four conditions: sum zero, sum negative, overflow, carry, in that order
// - low four instruction bits mask which conditions are tested
// - instruction bits four to seven give each tested condition's state
// - matched conditions anded with mask; any set bit means met
// - non-negative test: mask zero and negative, state zero set, negative clear
`timescale 1ns/100ps
`default_nettype none

module conditional_instruction_evaluator
(
    input  wire logic                                clock_i,
    input  wire logic                                rst_b_i,
    input  wire logic                                instr_valid_i,
    input  wire logic [cond_eval_pkg::INSTR_W-1:0]   instr_i,
    input  wire logic [cond_eval_pkg::DATA_W-1:0]    main_sum_register_i,
    input  wire logic                                overflow_i,
    input  wire logic                                carry_i,
    input  wire logic                                test_control_flag_i,
    input  wire logic                                branch_input_pin_i,
    output logic                                     cond_valid_o,
    output logic                                     cond_met_o,
    output logic                                     flag_met_o,
    output logic                                     arith_met_o,
    output logic [cond_eval_pkg::COND_W-1:0]         arith_condition_field_o
);
    // ========================================================================
    // flag select decode, used by the flag match logic only
    function automatic logic flag_sel_met
    (
        input logic [cond_eval_pkg::SEL_W-1:0] sel,
        input logic                            pin,
        input logic                            tc
    );
        logic hit;
        hit = 1'b0;
        case (cond_eval_pkg::flag_sel_t'(sel))
            cond_eval_pkg::SEL_PIN_LOW:  hit = ~pin;
            cond_eval_pkg::SEL_TC_SET:   hit = tc;
            cond_eval_pkg::SEL_TC_CLEAR: hit = ~tc;
            cond_eval_pkg::SEL_NONE:     hit = 1'b0;
            default:                     hit = 1'b0;
        endcase
        return hit;
    endfunction

    logic                                 pin_meta;
    logic                                 pin_sync;
    logic [cond_eval_pkg::COND_W-1:0]     next_cond;
    logic [cond_eval_pkg::SEL_W-1:0]      sel_field;
    logic                                 next_flag_met;
    arith_cond_if                         ac ();

    // ========================================================================
    // the branch pin is asynchronous, two flops before anything reads it
    always_ff @(posedge clock_i)
    begin
        if (!rst_b_i)
        begin
            pin_meta <= 1'b1;
            pin_sync <= 1'b1;
        end
        else
        begin
            pin_meta <= branch_input_pin_i;
            pin_sync <= pin_meta;
        end
    end

    // ========================================================================
    // build condition set
    always_comb
    begin
        next_cond                           = cond_eval_pkg::RST_COND;
        next_cond[cond_eval_pkg::COND_ZERO] = (main_sum_register_i == '0);
        next_cond[cond_eval_pkg::COND_NEG]  = main_sum_register_i[cond_eval_pkg::DATA_W-1];
        next_cond[cond_eval_pkg::COND_OVF]  = overflow_i;
        next_cond[cond_eval_pkg::COND_CRY]  = carry_i;
    end

    // ========================================================================
    // mask and state fields
    // non-negative test falls out of mask and state
    assign ac.mask  = instr_i[cond_eval_pkg::MASK_LSB +: cond_eval_pkg::COND_W];
    assign ac.state = instr_i[cond_eval_pkg::STATE_LSB +: cond_eval_pkg::COND_W];
    assign ac.cond  = next_cond;

    arith_cond_match u_match
    (
        .ac (ac)
    );

    // ========================================================================
    // flag select decode
    assign sel_field     = instr_i[cond_eval_pkg::SEL_LSB +: cond_eval_pkg::SEL_W];
    assign next_flag_met = flag_sel_met(sel_field, pin_sync, test_control_flag_i);

    // ========================================================================
    // valid strobe, one cycle after each request
    always_ff @(posedge clock_i)
    begin
        if (!rst_b_i)
            cond_valid_o <= cond_eval_pkg::RST_BIT;
        else
            cond_valid_o <= instr_valid_i;
    end

    // ========================================================================
    // results hold between requests so the decoder may sample late
    always_ff @(posedge clock_i)
    begin
        if (!rst_b_i)
        begin
            flag_met_o              <= cond_eval_pkg::RST_BIT;
            arith_met_o             <= cond_eval_pkg::RST_BIT;
            cond_met_o              <= cond_eval_pkg::RST_BIT;
            arith_condition_field_o <= cond_eval_pkg::RST_COND;
        end
        else if (instr_valid_i)
        begin
            flag_met_o              <= next_flag_met;
            arith_met_o             <= ac.met;
            // either part satisfies the instruction
            cond_met_o              <= next_flag_met | ac.met;
            arith_condition_field_o <= next_cond;
        end
    end

    // ========================================================================
    // checks
    a_zero_cond: assert property (
        @(posedge clock_i) disable iff (!rst_b_i)
        cond_valid_o |-> arith_condition_field_o[cond_eval_pkg::COND_ZERO]
                         == ($past(main_sum_register_i) == '0))
        else $error("zero condition does not follow sum register");

    a_cond_order: assert property (
        @(posedge clock_i) disable iff (!rst_b_i)
        cond_valid_o |-> arith_condition_field_o[2:0]
                         == {$past(main_sum_register_i[15]), $past(overflow_i),
                             $past(carry_i)})
        else $error("negative overflow carry order wrong");

    a_empty_mask: assert property (
        @(posedge clock_i) disable iff (!rst_b_i)
        (instr_valid_i && instr_i[3:0] == 4'h0) |=> !arith_met_o)
        else $error("empty mask gave arithmetic match");

    a_state_match: assert property (
        @(posedge clock_i) disable iff (!rst_b_i)
        instr_valid_i |=> arith_met_o
            == |($past(instr_i[3:0]) & ~(arith_condition_field_o ^ $past(instr_i[7:4]))))
        else $error("arithmetic match disagrees with mask and state");

    a_any_bit: assert property (
        @(posedge clock_i) disable iff (!rst_b_i)
        (instr_valid_i && (ac.mask & ~(ac.cond ^ ac.state)) != 4'h0) |=> arith_met_o)
        else $error("matched masked condition not reported");

    a_nonneg_test: assert property (
        @(posedge clock_i) disable iff (!rst_b_i)
        (instr_valid_i && instr_i[7:0] == 8'h8C) |=>
            arith_met_o == ($past(main_sum_register_i[15]) == 1'b0))
        else $error("non-negative test wrong");

    a_sel_none: assert property (
        @(posedge clock_i) disable iff (!rst_b_i)
        (instr_valid_i && instr_i[9:8] == 2'h3) |=> !flag_met_o)
        else $error("select 11 produced a flag match");

    a_tc_select: assert property (
        @(posedge clock_i) disable iff (!rst_b_i)
        (instr_valid_i && instr_i[9] != instr_i[8]) |=>
            flag_met_o == ($past(test_control_flag_i) == $past(instr_i[8])))
        else $error("test flag select wrong");

    a_pin_low: assert property (
        @(posedge clock_i) disable iff (!rst_b_i)
        (instr_valid_i && instr_i[9:8] == 2'h0) |=> flag_met_o == !$past(pin_sync))
        else $error("pin low select wrong");

endmodule

`default_nettype wire
